//--- hdl/typec_event_status_regs.v
`include "typec_event_defines.vh"

// Contract
// RQ1 - The recovery flag latches 1 when a reported fault recovers and reads 0 while it has not.
// RQ2 - The fault-present flag reads 1 while any fault exists and 0 otherwise.
// RQ3 - The fault-present flag follows the live condition directly and is never latched.
// RQ4 - Reading the event register leaves the fault-present flag untouched.
// RQ5 - Only latched event flags can raise the interrupt, never the fault-present flag.
// RQ6 - At power-up the port-role field loads 10 for a floating strap, 01 for high and 00 for low.
// RQ7 - The strap is taken into the port-role field only once and later pin changes are ignored.
// RQ8 - After initialisation the bus master may overwrite the port-role field and the device uses it.
// RQ9 - Each latched event flag clears when a bus read of the event register completes.
module typec_event_status_regs #(
   parameter [6:0] BUS_ADDR = `BUS_ADDR_DEFAULT
) (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out_q,
   output reg        sda_oe_q,
   input  wire       strap_high,
   input  wire       strap_low,
   input  wire       attach_pulse,
   input  wire       detach_pulse,
   input  wire       overtemp_pulse,
   input  wire       overvoltage_event,
   input  wire       overcurrent_event,
   input  wire       recovery_pulse,
   input  wire       fault_active,
   input  wire [7:0] attach_status,
   output reg  [7:0] control_q,
   output reg        int_n_q
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_ADDR  = 3'h1;
   localparam [2:0] ST_AACK  = 3'h2;
   localparam [2:0] ST_WBYTE = 3'h3;
   localparam [2:0] ST_WACK  = 3'h4;
   localparam [2:0] ST_RBYTE = 3'h5;
   localparam [2:0] ST_RACK  = 3'h6;

   wire [3:0] pins_q;
   reg        scl_d1_q;
   reg        sda_d1_q;
   reg  [2:0] state_q;
   reg  [2:0] bit_cnt_q;
   reg  [7:0] shift_q;
   reg  [7:0] ptr_q;
   reg        rw_q;
   reg        first_q;
   reg        wr_en_q;
   reg  [7:0] wr_ptr_q;
   reg  [7:0] wr_data_q;
   reg        rd_clr_q;
   reg        addr_full_q;
   reg  [7:0] latch_q;
   reg  [2:0] strap_cnt_q;
   reg        strap_done_q;
   wire       scl_f;
   wire       sda_f;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire [7:0] event_view;
   wire [7:0] latch_set;
   wire [7:0] rd_cur;
   wire [7:0] rd_nxt;

   pin_filter #(.W(4)) u_pins (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .pin     ({strap_low, strap_high, sda_in, scl_in}),
      .level_q (pins_q)
   );

   assign scl_f     = pins_q[0];
   assign sda_f     = pins_q[1];
   assign scl_rise  = scl_f & ~scl_d1_q;
   assign scl_fall  = ~scl_f & scl_d1_q;
   assign start_det = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
   assign stop_det  = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

   // Live fault bit is wired in from the condition, not from a flop.
   assign event_view = (latch_q & `EVT_LATCH_MASK) | ({7'h00, fault_active} << `EVT_FAULT_NOW_BIT); // RQ2 RQ3

   function [7:0] reg_read;
      input [7:0] a;
      begin
         case (a)
            `ADDR_DEVICE_ID:     reg_read = `DEVICE_ID_VALUE;
            `ADDR_CONTROL:       reg_read = control_q;
            `ADDR_EVENT_FLAGS:   reg_read = event_view;
            `ADDR_ATTACH_STATUS: reg_read = attach_status;
            default:             reg_read = `READ_UNMAPPED;
         endcase
      end
   endfunction

   assign rd_cur = reg_read(ptr_q);
   assign rd_nxt = reg_read(ptr_q + 8'h01);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_d1_q <= scl_f;
         sda_d1_q <= sda_f;
      end
   end

   // Bus slave: pointer byte first, then data bytes with auto-increment.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shift_q   <= 8'h00;
         ptr_q     <= 8'h00;
         rw_q      <= 1'b0;
         first_q   <= 1'b0;
         wr_en_q   <= 1'b0;
         wr_ptr_q  <= 8'h00;
         wr_data_q <= 8'h00;
         rd_clr_q  <= 1'b0;
         addr_full_q <= 1'b0;
         sda_out_q <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else begin
         wr_en_q  <= 1'b0;
         rd_clr_q <= 1'b0;
         if (start_det) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 3'h0;
            addr_full_q <= 1'b0;
            sda_oe_q  <= 1'b0;
         end else if (stop_det) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else if (scl_rise) begin
            case (state_q)
               ST_ADDR, ST_WBYTE: begin
                  shift_q   <= {shift_q[6:0], sda_f};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  // The clock fall right after a start carries no address, so only a full byte is decoded.
                  if (state_q == ST_ADDR && bit_cnt_q == 3'h7) begin
                     addr_full_q <= 1'b1;
                  end
               end
               ST_RBYTE: begin
                  bit_cnt_q <= bit_cnt_q + 3'h1;
               end
               ST_RACK: begin
                  rw_q <= ~sda_f;
                  if (ptr_q == `ADDR_EVENT_FLAGS) begin
                     rd_clr_q <= 1'b1; // RQ9
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state_q)
               ST_ADDR: begin
                  if (bit_cnt_q == 3'h0 && addr_full_q) begin
                     if (shift_q[7:1] == BUS_ADDR) begin
                        state_q  <= ST_AACK;
                        rw_q     <= shift_q[0];
                        sda_oe_q <= 1'b1;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  bit_cnt_q <= 3'h0;
                  first_q   <= 1'b1;
                  if (rw_q) begin
                     state_q  <= ST_RBYTE;
                     shift_q  <= rd_cur;
                     sda_oe_q <= ~rd_cur[7];
                  end else begin
                     state_q  <= ST_WBYTE;
                     sda_oe_q <= 1'b0;
                  end
               end
               ST_WBYTE: begin
                  if (bit_cnt_q == 3'h0) begin
                     state_q  <= ST_WACK;
                     sda_oe_q <= 1'b1;
                     first_q  <= 1'b0;
                     if (first_q) begin
                        ptr_q <= shift_q;
                     end else begin
                        wr_en_q   <= 1'b1;
                        wr_ptr_q  <= ptr_q;
                        wr_data_q <= shift_q;
                        ptr_q     <= ptr_q + 8'h01;
                     end
                  end
               end
               ST_WACK: begin
                  state_q  <= ST_WBYTE;
                  sda_oe_q <= 1'b0;
               end
               ST_RBYTE: begin
                  if (bit_cnt_q == 3'h0) begin
                     state_q  <= ST_RACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     shift_q  <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= ~shift_q[6];
                  end
               end
               ST_RACK: begin
                  ptr_q <= ptr_q + 8'h01;
                  if (rw_q) begin
                     state_q  <= ST_RBYTE;
                     shift_q  <= rd_nxt;
                     sda_oe_q <= ~rd_nxt[7];
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
               default: begin
                  state_q  <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Control register with one-time strap load of the port-role field.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         control_q    <= `CONTROL_RESET;
         strap_cnt_q  <= 3'h0;
         strap_done_q <= 1'b0;
      end else begin
         if (!strap_done_q) begin // RQ7
            if (strap_cnt_q == `STRAP_WAIT_CYCLES) begin
               strap_done_q <= 1'b1;
               if (pins_q[2] & ~pins_q[3]) begin
                  control_q[`CTRL_PORT_MSB:`CTRL_PORT_LSB] <= `ROLE_HOST; // RQ6
               end else if (pins_q[3] & ~pins_q[2]) begin
                  control_q[`CTRL_PORT_MSB:`CTRL_PORT_LSB] <= `ROLE_DEVICE; // RQ6
               end else begin
                  control_q[`CTRL_PORT_MSB:`CTRL_PORT_LSB] <= `ROLE_DUAL; // RQ6
               end
            end else begin
               strap_cnt_q <= strap_cnt_q + 3'h1;
            end
         end else if (wr_en_q && wr_ptr_q == `ADDR_CONTROL) begin
            control_q <= wr_data_q; // RQ8
         end
      end
   end

   assign latch_set = {recovery_pulse, overcurrent_event, overvoltage_event, 1'b0,
                       overtemp_pulse, 1'b0, detach_pulse, attach_pulse};

   // Latched flags: a new event in the clearing cycle survives.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= `EVENT_RESET;
      end else if (rd_clr_q) begin
         latch_q <= latch_set & `EVT_LATCH_MASK; // RQ4 RQ9
      end else begin
         latch_q <= (latch_q | latch_set) & `EVT_LATCH_MASK; // RQ1
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_n_q <= 1'b1;
      end else begin
         int_n_q <= ~((|latch_q) & ~control_q[`CTRL_MASK_BIT]); // RQ5
      end
   end

endmodule

//--- hdl/typec_event_defines.vh
`ifndef TYPEC_EVENT_DEFINES_VH
`define TYPEC_EVENT_DEFINES_VH

// Register offsets.
`define ADDR_DEVICE_ID        8'h01
`define ADDR_CONTROL          8'h02
`define ADDR_EVENT_FLAGS      8'h03
`define ADDR_ATTACH_STATUS    8'h04

// Reset values, and the value read at unmapped offsets.
`define CONTROL_RESET         8'h00
`define EVENT_RESET           8'h00
`define READ_UNMAPPED         8'h00

// Identity byte, value is arbitrary.
`define DEVICE_ID_VALUE       8'h5A

// Default 7-bit bus address, value is arbitrary.
`define BUS_ADDR_DEFAULT      7'h1D

// Control register fields.
`define CTRL_MASK_BIT         0
`define CTRL_PORT_LSB         1
`define CTRL_PORT_MSB         2

// Event register fields.
`define EVT_ATTACH_BIT        0
`define EVT_DETACH_BIT        1
`define EVT_FAULT_NOW_BIT     2
`define EVT_OVERTEMP_BIT      3
`define EVT_OVERVOLT_BIT      5
`define EVT_OVERCUR_BIT       6
`define EVT_RECOVERY_BIT      7
`define EVT_LATCH_MASK        8'hEB

// Port-role codes loaded from the strap.
`define ROLE_DEVICE           2'h0
`define ROLE_HOST             2'h1
`define ROLE_DUAL             2'h2

// Cycles after reset release before the strap is taken.
`define STRAP_WAIT_CYCLES     3'h4

`endif

//--- hdl/pin_filter.v
// Three-stage pin synchroniser; the output follows once stages two and three agree.
module pin_filter #(
   parameter W = 1
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire [W-1:0] pin,
   output reg  [W-1:0] level_q
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[i]    <= 1'b1;
               s2_q[i]    <= 1'b1;
               s3_q[i]    <= 1'b1;
               level_q[i] <= 1'b1;
            end else begin
               s1_q[i] <= pin[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  level_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

endmodule

//--- tb/typec_event_checker_assertions.sv
module typec_event_checker (
   input wire       mclk,
   input wire       rst_n,
   input wire       scl_in,
   input wire       strap_high,
   input wire       strap_low,
   input wire       attach_pulse,
   input wire       detach_pulse,
   input wire       overtemp_pulse,
   input wire       overvoltage_event,
   input wire       overcurrent_event,
   input wire       recovery_pulse,
   input wire       fault_active,
   input wire [7:0] control_q,
   input wire       int_n_q
);
   timeunit 1ns;
   timeprecision 1ns;
   reg  [3:0] cnt_q;
   wire       evt = attach_pulse | detach_pulse | overtemp_pulse |
                    overvoltage_event | overcurrent_event | recovery_pulse;
   wire [1:0] role = (strap_high ^ strap_low) ? {1'h0, strap_high} : 2'h2;
   // Counts edges after reset release, saturating at 15.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'hF) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_role_from_strap: assert property (cnt_q == 4'h7 |-> control_q == {5'h00, role, 1'h0})
      else $error("role not loaded");
   a_strap_ignored: assert property ((cnt_q == 4'hF && $changed(strap_high)) |=> $stable(control_q) [*8])
      else $error("strap taken again");
   a_role_bus_write: assert property ((cnt_q == 4'hF && $changed(control_q)) |-> !scl_in && !$past(scl_in, 3))
      else $error("control changed off bus");
   a_recovery_irq: assert property ((recovery_pulse && !control_q[0]) |-> ##2 !int_n_q)
      else $error("recovery missed");
   a_event_irq: assert property ((evt && !control_q[0]) |-> ##2 !int_n_q)
      else $error("event missed");
   a_irq_needs_event: assert property ($fell(int_n_q) |-> $past(evt, 2))
      else $error("irq without event");
   a_fault_no_irq: assert property (($changed(fault_active) && int_n_q && !evt && !$past(evt)) |=> int_n_q)
      else $error("fault raised irq");
   a_read_clears_irq: assert property ($rose(int_n_q) |-> scl_in && $past(scl_in, 2))
      else $error("irq cleared off read");
   c_strap_host: cover property (cnt_q == 4'h7 && control_q[2:1] == 2'h1);
   c_irq_low: cover property ($fell(int_n_q));
   c_irq_clear: cover property ($rose(int_n_q));
endmodule

bind typec_event_status_regs typec_event_checker chk (.*);

//--- tb/i2c_host_model.sv
`include "typec_event_defines.vh"
module i2c_host_model (
   input  wire  mclk,
   input  wire  sda,
   output logic scl = 1'h1,
   output logic pull = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Data moves early in the low phase and is sampled late in the high phase.
   task automatic bit_io(input logic b, output logic r);
      tick(4);
      pull <= ~b;
      tick(16);
      scl <= 1'h1;
      tick(16);
      r = sda;
      scl <= 1'h0;
   endtask
   // Start or repeated start, once the device has let go of the data line.
   task automatic start;
      tick(8);
      pull <= 1'h0;
      scl <= 1'h1;
      tick(16);
      pull <= 1'h1;
      tick(16);
      scl <= 1'h0;
   endtask
   task automatic stop;
      tick(4);
      pull <= 1'h1;
      tick(16);
      scl <= 1'h1;
      tick(16);
      pull <= 1'h0;
      tick(16);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(1'h1, a);
   endtask
   task automatic access(input logic rd, input logic [7:0] p, input logic [7:0] d, output logic [7:0] v);
      logic [7:0] q;
      start();
      xfer({`BUS_ADDR_DEFAULT, 1'h0}, q);
      xfer(p, q);
      if (rd) begin
         start();
         xfer({`BUS_ADDR_DEFAULT, 1'h1}, q);
      end
      xfer(d, v);
      stop();
   endtask
endmodule

//--- tb/test_typec_event_status_regs.sv
`include "typec_event_defines.vh"
module test_typec_event_status_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic       mclk = 1'h0;
   logic       rst_n = 1'h0;
   logic       strap_high = 1'h0;
   logic       strap_low = 1'h0;
   logic       fault_active = 1'h0;
   logic [5:0] evt = 6'h00;
   logic [7:0] attach_status = 8'h25;
   logic [7:0] v;
   logic [7:0] control_q;
   logic       int_n_q;
   logic       sda_out_q;
   logic       sda_oe_q;
   logic       scl_in;
   logic       pull;
   int         err_total = 0;
   int         check_count = 0;
   int         cycles = 0;
   wire        sda_in = ~(pull | (sda_oe_q & ~sda_out_q));
   typec_event_status_regs dut (
      .*,
      .attach_pulse(evt[0]),
      .detach_pulse(evt[1]),
      .overtemp_pulse(evt[2]),
      .overvoltage_event(evt[3]),
      .overcurrent_event(evt[4]),
      .recovery_pulse(evt[5])
   );
   i2c_host_model host (.mclk(mclk), .sda(sda_in), .scl(scl_in), .pull(pull));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] exp);
      host.access(1'h1, p, 8'hFF, v);
      check($sformatf("register %h", p), v, exp);
   endtask
   task automatic pulse(input logic [5:0] m);
      evt <= m;
      @(posedge mclk);
      evt <= 6'h00;
      repeat (4) @(posedge mclk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      static logic [7:0] role_tab [4] = '{8'h04, 8'h02, 8'h00, 8'h04};
      static logic [7:0] evt_tab [6] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h40, 8'h80};
      for (int s = 0; s < 4; s++) begin
         rst_n <= 1'h0;
         strap_high <= s[0];
         strap_low <= s[1];
         repeat (10) @(posedge mclk);
         rst_n <= 1'h1;
         repeat (20) @(posedge mclk);
         check("role", control_q, role_tab[s]);
         strap_high <= ~strap_high;
         repeat (20) @(posedge mclk);
         check("role kept", control_q, role_tab[s]);
      end
      $display("test strap done");
      host.access(1'h0, `ADDR_CONTROL, 8'h02, v);
      check("role write", control_q, 8'h02);
      rd(`ADDR_CONTROL, 8'h02);
      rd(`ADDR_ATTACH_STATUS, 8'h25);
      rd(8'h07, 8'h00);
      $display("test control done");
      fault_active <= 1'h1;
      repeat (4) @(posedge mclk);
      check("irq", {7'h00, int_n_q}, 8'h01);
      rd(`ADDR_EVENT_FLAGS, 8'h04);
      rd(`ADDR_EVENT_FLAGS, 8'h04);
      fault_active <= 1'h0;
      rd(`ADDR_EVENT_FLAGS, 8'h00);
      for (int i = 0; i < 6; i++) begin
         pulse(6'h01 << i);
         check("irq", {7'h00, int_n_q}, 8'h00);
         rd(`ADDR_EVENT_FLAGS, evt_tab[i]);
         rd(`ADDR_EVENT_FLAGS, 8'h00);
      end
      fault_active <= 1'h1;
      pulse(6'h3F);
      rd(`ADDR_EVENT_FLAGS, 8'hEF);
      rd(`ADDR_EVENT_FLAGS, 8'h04);
      check("irq", {7'h00, int_n_q}, 8'h01);
      $display("test events done");
      stop_test();
   end
endmodule
